//--- hw/afcc_map.svh
// Register map, field positions and codes of the analog front-end control
// Operation
// - Two four-bit fields route any input or common input to each amp side
// - Monitor choice shorts both amp inputs together at mid-supply
// - Monitor choices for quarter analog span, quarter digital supply, temp
// - Channel change: hold inputs at mid-supply two clocks, then connect
// - Three-bit gain field decodes to gains 1 through 128
// - Amp power field 00 bypasses and powers down, 01 enables the amp
// - Gains 64 and 128 set analog gain 32 plus digital scaling
// - Amp bypass allowed only while gain setting equals 1
// - Two-bit field picks internal or external reference, reset external 0
// - Reference select code 10 routes the internal reference
// - Power code 10 keeps reference on, 01 drops it in power-down
// - Internal reference stays off after reset until software enables it
// - All fields are written over the serial interface
`ifndef AFCC_MAP_SVH
`define AFCC_MAP_SVH

`define AFCC_OFS_INPUT_SEL 8'h02
`define AFCC_OFS_GAIN 8'h03
`define AFCC_OFS_REF_CTRL 8'h05
`define AFCC_OFS_MONITOR 8'h09
`define AFCC_OFS_STATUS 8'h0a

`define AFCC_RST_INPUT_SEL 8'h01
`define AFCC_RST_GAIN 8'h00
`define AFCC_RST_REF_CTRL 8'h00
`define AFCC_RST_MONITOR 8'h00
`define AFCC_RDATA_ZERO 8'h00

`define AFCC_POS_MSB 7
`define AFCC_POS_LSB 4
`define AFCC_NEG_MSB 3
`define AFCC_NEG_LSB 0
`define AFCC_GAIN_MSB 2
`define AFCC_GAIN_LSB 0
`define AFCC_AMP_MSB 6
`define AFCC_AMP_LSB 5
`define AFCC_REFPWR_MSB 3
`define AFCC_REFPWR_LSB 2
`define AFCC_REFSEL_MSB 1
`define AFCC_REFSEL_LSB 0
`define AFCC_MON_MSB 2
`define AFCC_MON_LSB 0

`define AFCC_AMP_OFF 2'h0
`define AFCC_AMP_ON 2'h1
`define AFCC_REFSEL_EXT0 2'h0
`define AFCC_REFSEL_INT 2'h2
`define AFCC_REFPWR_OFF 2'h0
`define AFCC_REFPWR_ON_PD 2'h1
`define AFCC_REFPWR_ON 2'h2
`define AFCC_GAIN_1 3'h0
`define AFCC_GAIN_32 3'h5
`define AFCC_SHIFT_NONE 2'h0
`define AFCC_INPUT_COMMON 4'hc
`define AFCC_RST_POS 4'h0
`define AFCC_RST_NEG 4'h1

`define AFCC_BBM_CLKS 2'h2
`define AFCC_CNT_ZERO 2'h0
`define AFCC_CNT_ONE 2'h1

`endif

//--- hw/afcc_pkg.sv
// Types of the analog front-end control block
package afcc_pkg;

    // Break-before-make sequencer states, Gray along the path
    typedef enum logic [1:0] {
        AFCC_BBM_CONNECTED = 2'h0,
        AFCC_BBM_BREAK = 2'h1
    } afcc_bbm_state_t;

    // System monitor selections
    typedef enum logic [2:0] {
        AFCC_MON_NONE = 3'h0,
        AFCC_MON_SHORT = 3'h1,
        AFCC_MON_TEMP = 3'h2,
        AFCC_MON_AVDD4 = 3'h3,
        AFCC_MON_DVDD4 = 3'h4
    } afcc_mon_t;

    typedef struct packed {
        afcc_bbm_state_t state;
        logic [1:0] cnt;
        logic [3:0] pos;
        logic [3:0] neg;
        afcc_mon_t mon;
    } afcc_bbm_st_t;

    typedef struct packed {
        logic [7:0] input_sel_reg;
        logic [7:0] gain_reg;
        logic [7:0] ref_ctrl_reg;
        logic [7:0] monitor_reg;
        logic [7:0] rdata;
        logic rvalid;
        logic amp_en;
        logic [2:0] ana_gain;
        logic [1:0] dig_shift;
        logic [1:0] ref_src;
        logic ref_on;
    } afcc_top_st_t;

endpackage

//--- hw/afcc_bbm.sv
// Break-before-make sequencer for the input multiplexer
`timescale 1ns/1ps
`include "afcc_map.svh"

module afcc_bbm (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Requested selection
    input wire logic [3:0] i_req_pos,
    input wire logic [3:0] i_req_neg,
    input wire afcc_pkg::afcc_mon_t i_req_mon,
    // Applied selection
    output logic [3:0] o_pos,
    output logic [3:0] o_neg,
    output afcc_pkg::afcc_mon_t o_mon,
    output logic o_break
);

    afcc_pkg::afcc_bbm_st_t st_reg;
    afcc_pkg::afcc_bbm_st_t st_next;
    logic changed;

    // Any difference between request and applied starts a break
    assign changed = (i_req_pos != st_reg.pos) || (i_req_neg != st_reg.neg)
        || (i_req_mon != st_reg.mon);

    // Next-state logic
    always_comb begin
        st_next = st_reg;
        unique case (st_reg.state)
            afcc_pkg::AFCC_BBM_CONNECTED: begin
                if (changed) begin
                    st_next.state = afcc_pkg::AFCC_BBM_BREAK;
                    st_next.cnt = `AFCC_CNT_ZERO;
                end
            end
            afcc_pkg::AFCC_BBM_BREAK: begin
                // two clocks, connect
                // Latest request wins, so rapid rewrites never short inputs
                if (st_reg.cnt == `AFCC_BBM_CLKS - `AFCC_CNT_ONE) begin
                    st_next.state = afcc_pkg::AFCC_BBM_CONNECTED;
                    st_next.pos = i_req_pos;
                    st_next.neg = i_req_neg;
                    st_next.mon = i_req_mon;
                end else begin
                    st_next.cnt = st_reg.cnt + `AFCC_CNT_ONE;
                end
            end
            default: begin
                st_next.state = afcc_pkg::AFCC_BBM_BREAK;
                st_next.cnt = `AFCC_CNT_ZERO;
            end
        endcase
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_reg <= '{state: afcc_pkg::AFCC_BBM_CONNECTED,
                cnt: `AFCC_CNT_ZERO, pos: `AFCC_RST_POS, neg: `AFCC_RST_NEG,
                mon: afcc_pkg::AFCC_MON_NONE};
        end else if (i_clk_en) begin
            st_reg <= st_next;
        end
    end

    assign o_pos = st_reg.pos;
    assign o_neg = st_reg.neg;
    assign o_mon = st_reg.mon;
    assign o_break = (st_reg.state == afcc_pkg::AFCC_BBM_BREAK);

endmodule // afcc_bbm

//--- hw/afcc_top.sv
// Analog front-end configuration and sequencing control
`timescale 1ns/1ps
`include "afcc_map.svh"

module afcc_top (
    // Clock, reset and clock enable
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Register port from the serial command decoder
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Device power-down mode
    input wire logic i_power_down,
    // Input multiplexer controls
    output logic [3:0] o_pos_input_select,
    output logic [3:0] o_neg_input_select,
    output logic o_inputs_mid_supply,
    output logic o_inputs_connected,
    output logic o_mon_temp_sensor,
    output logic o_mon_avdd_quarter,
    output logic o_mon_dvdd_quarter,
    // Amplifier controls
    output logic o_amp_enable,
    output logic [2:0] o_amp_analog_gain,
    output logic [1:0] o_digital_shift,
    // Reference controls
    output logic [1:0] o_ref_source_select,
    output logic o_internal_ref_on
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Analog gain saturates at 32; the rest is done digitally
    function automatic logic [2:0] f_analog_gain(input logic [2:0] g);
        f_analog_gain = (g > `AFCC_GAIN_32) ? `AFCC_GAIN_32 : g;
    endfunction

    // Left shift of the result that makes up the missing gain
    function automatic logic [1:0] f_digital_shift(input logic [2:0] g);
        logic [2:0] d;
        d = (g > `AFCC_GAIN_32) ? (g - `AFCC_GAIN_32) : 3'h0;
        f_digital_shift = d[1:0];
    endfunction

    // Amp stays on unless bypass is asked and gain is unity
    function automatic logic f_amp_on(input logic [1:0] p,
        input logic [2:0] g);
        f_amp_on = !((p == `AFCC_AMP_OFF) && (g == `AFCC_GAIN_1));
    endfunction

    // Reference power decode against power-down mode
    function automatic logic f_ref_on(input logic [1:0] p, input logic pd);
        f_ref_on = (p == `AFCC_REFPWR_ON) ||
            ((p == `AFCC_REFPWR_ON_PD) && !pd);
    endfunction

    // Unknown monitor codes fall back to no monitor
    function automatic afcc_pkg::afcc_mon_t f_mon(input logic [2:0] m);
        afcc_pkg::afcc_mon_t r;
        r = afcc_pkg::AFCC_MON_NONE;
        if (m <= afcc_pkg::AFCC_MON_DVDD4) begin
            r = afcc_pkg::afcc_mon_t'(m);
        end
        f_mon = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    afcc_pkg::afcc_top_st_t st_reg;
    afcc_pkg::afcc_top_st_t st_next;
    logic mux_break;
    logic [3:0] pos_applied;
    logic [3:0] neg_applied;
    afcc_pkg::afcc_mon_t mon_applied;
    afcc_pkg::afcc_mon_t mon_req;
    logic [1:0] amp_wr_field;
    logic [7:0] status_word;

    assign mon_req = f_mon(st_reg.monitor_reg[`AFCC_MON_MSB:`AFCC_MON_LSB]);
    assign amp_wr_field = i_reg_wdata[`AFCC_AMP_MSB:`AFCC_AMP_LSB];

    // Live state for software: break busy, amp, reference power
    assign status_word = {5'h00, st_reg.ref_on, st_reg.amp_en, mux_break};

    ////////////////////////////////////////////////////////////////////////
    // Register writes, reads and decoded controls

    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                `AFCC_OFS_INPUT_SEL: st_next.input_sel_reg = i_reg_wdata;
                `AFCC_OFS_GAIN: begin
                    st_next.gain_reg[`AFCC_GAIN_MSB:`AFCC_GAIN_LSB] =
                        i_reg_wdata[`AFCC_GAIN_MSB:`AFCC_GAIN_LSB];
                    // Reserved amp codes are dropped; old setting is kept
                    if (amp_wr_field == `AFCC_AMP_OFF ||
                        amp_wr_field == `AFCC_AMP_ON) begin
                        st_next.gain_reg[`AFCC_AMP_MSB:`AFCC_AMP_LSB] =
                            amp_wr_field;
                    end
                end
                `AFCC_OFS_REF_CTRL: st_next.ref_ctrl_reg = i_reg_wdata;
                `AFCC_OFS_MONITOR: st_next.monitor_reg = i_reg_wdata;
                default: ;
            endcase
        end
        // Reads answer one clock later; unmapped offsets read zero
        if (i_reg_rd) begin
            st_next.rvalid = 1'b1;
            unique case (i_reg_addr)
                `AFCC_OFS_INPUT_SEL: st_next.rdata = st_reg.input_sel_reg;
                `AFCC_OFS_GAIN: st_next.rdata = st_reg.gain_reg;
                `AFCC_OFS_REF_CTRL: st_next.rdata = st_reg.ref_ctrl_reg;
                `AFCC_OFS_MONITOR: st_next.rdata = st_reg.monitor_reg;
                `AFCC_OFS_STATUS: st_next.rdata = status_word;
                default: st_next.rdata = `AFCC_RDATA_ZERO;
            endcase
        end
        st_next.amp_en = f_amp_on(
            st_reg.gain_reg[`AFCC_AMP_MSB:`AFCC_AMP_LSB],
            st_reg.gain_reg[`AFCC_GAIN_MSB:`AFCC_GAIN_LSB]);
        // cap analog at 32
        // Bypassed amp is only ever at unity, so no scaling applies then
        st_next.ana_gain = f_analog_gain(
            st_reg.gain_reg[`AFCC_GAIN_MSB:`AFCC_GAIN_LSB]);
        st_next.dig_shift = f_digital_shift(
            st_reg.gain_reg[`AFCC_GAIN_MSB:`AFCC_GAIN_LSB]);
        st_next.ref_src =
            st_reg.ref_ctrl_reg[`AFCC_REFSEL_MSB:`AFCC_REFSEL_LSB];
        st_next.ref_on = f_ref_on(
            st_reg.ref_ctrl_reg[`AFCC_REFPWR_MSB:`AFCC_REFPWR_LSB],
            i_power_down);
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            st_reg <= '{input_sel_reg: `AFCC_RST_INPUT_SEL,
                gain_reg: `AFCC_RST_GAIN, ref_ctrl_reg: `AFCC_RST_REF_CTRL,
                monitor_reg: `AFCC_RST_MONITOR, rdata: `AFCC_RDATA_ZERO,
                rvalid: 1'b0, amp_en: 1'b0, ana_gain: `AFCC_GAIN_1,
                dig_shift: `AFCC_SHIFT_NONE, ref_src: `AFCC_REFSEL_EXT0,
                ref_on: 1'b0};
        end else if (i_clk_en) begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break-before-make channel switching

    afcc_bbm u_bbm (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_req_pos(st_reg.input_sel_reg[`AFCC_POS_MSB:`AFCC_POS_LSB]),
        .i_req_neg(st_reg.input_sel_reg[`AFCC_NEG_MSB:`AFCC_NEG_LSB]),
        .i_req_mon(mon_req),
        .o_pos(pos_applied),
        .o_neg(neg_applied),
        .o_mon(mon_applied),
        .o_break(mux_break)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_pos_input_select = pos_applied;
    assign o_neg_input_select = neg_applied;
    assign o_inputs_mid_supply = mux_break ||
        (mon_applied == afcc_pkg::AFCC_MON_SHORT);
    // Pins connect only when no break and no monitor takes the inputs
    assign o_inputs_connected = !mux_break &&
        (mon_applied == afcc_pkg::AFCC_MON_NONE);
    assign o_mon_temp_sensor = !mux_break &&
        (mon_applied == afcc_pkg::AFCC_MON_TEMP);
    assign o_mon_avdd_quarter = !mux_break &&
        (mon_applied == afcc_pkg::AFCC_MON_AVDD4);
    assign o_mon_dvdd_quarter = !mux_break &&
        (mon_applied == afcc_pkg::AFCC_MON_DVDD4);

    assign o_amp_enable = st_reg.amp_en;
    assign o_amp_analog_gain = st_reg.ana_gain;
    assign o_digital_shift = st_reg.dig_shift;
    assign o_ref_source_select = st_reg.ref_src;
    assign o_internal_ref_on = st_reg.ref_on;
    assign o_reg_rdata = st_reg.rdata;
    assign o_reg_rvalid = st_reg.rvalid;

endmodule // afcc_top

//--- tb/afcc_top_props.sv
// Port-level assertions for the front-end control block
`timescale 1ns/1ps
module afcc_top_props (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Register port and mode
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic o_reg_rvalid,
    input wire logic i_power_down,
    // Front-end controls
    input wire logic [3:0] o_pos_input_select,
    input wire logic [3:0] o_neg_input_select,
    input wire logic o_inputs_mid_supply,
    input wire logic o_inputs_connected,
    input wire logic o_mon_temp_sensor,
    input wire logic o_mon_avdd_quarter,
    input wire logic o_mon_dvdd_quarter,
    input wire logic o_amp_enable,
    input wire logic [2:0] o_amp_analog_gain,
    input wire logic [1:0] o_digital_shift,
    input wire logic [1:0] o_ref_source_select,
    input wire logic o_internal_ref_on
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // Accepted write to one offset
    sequence s_wr(a);
        i_clk_en && i_reg_wr && i_reg_addr == a;
    endsequence
    // Only a real change counts, the old pair must be settled
    sequence s_chan;
        s_wr(8'h02) ##0 (o_inputs_connected &&
            i_reg_wdata != {o_pos_input_select, o_neg_input_select});
    endsequence
    // Both amp inputs parked at mid-supply for two clocks
    sequence s_break;
        (o_inputs_mid_supply && !o_inputs_connected)[*2];
    endsequence

    a_read_answer: assert property (
        i_clk_en && i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    a_break_make: assert property (s_chan |-> ##2 s_break ##1
        (o_inputs_connected &&
        {o_pos_input_select, o_neg_input_select} == $past(i_reg_wdata, 4)))
        else $error("channel change sequence wrong");
    a_conn_clean: assert property (o_inputs_connected |->
        !(o_inputs_mid_supply || o_mon_temp_sensor || o_mon_avdd_quarter ||
        o_mon_dvdd_quarter))
        else $error("monitor active while connected");
    a_gain_low: assert property (
        s_wr(8'h03) ##0 (i_reg_wdata[6:5] == 2'h1 &&
        i_reg_wdata[2:0] <= 3'h5) |-> ##2 o_amp_enable &&
        o_digital_shift == 2'h0 &&
        o_amp_analog_gain == $past(i_reg_wdata[2:0], 2))
        else $error("gain decode wrong");
    a_gain_high: assert property (
        s_wr(8'h03) ##0 (i_reg_wdata[6:5] == 2'h1 &&
        i_reg_wdata[2:1] == 2'h3) |-> ##2 o_amp_analog_gain == 3'h5 &&
        o_digital_shift ==
        {$past(i_reg_wdata[0], 2), !$past(i_reg_wdata[0], 2)})
        else $error("digital scaling wrong");
    a_bypass_unity: assert property (
        s_wr(8'h03) ##0 i_reg_wdata[6:5] == 2'h0
        |-> ##2 o_amp_enable == ($past(i_reg_wdata[2:0], 2) != 3'h0))
        else $error("bypass rule broken");
    a_ref_source: assert property (s_wr(8'h05) |-> ##2
        o_ref_source_select == $past(i_reg_wdata[1:0], 2))
        else $error("reference source wrong");
    a_ref_always: assert property (
        s_wr(8'h05) ##0 i_reg_wdata[3:2] == 2'h2
        |-> ##2 o_internal_ref_on)
        else $error("reference not kept on");
    a_ref_pdown: assert property (
        (s_wr(8'h05) ##0 (i_reg_wdata[3:2] == 2'h1 && i_power_down))
        ##1 i_power_down[*2] |-> !o_internal_ref_on)
        else $error("reference on in power-down");
    a_reset_state: assert property (
        $fell(i_sys_rst) |-> !o_internal_ref_on &&
        o_ref_source_select == 2'h0 && !o_amp_enable)
        else $error("reset state wrong");
endmodule // afcc_top_props

bind afcc_top afcc_top_props afcc_top_props_inst (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rvalid(o_reg_rvalid),
    .i_power_down(i_power_down), .o_pos_input_select(o_pos_input_select),
    .o_neg_input_select(o_neg_input_select),
    .o_inputs_mid_supply(o_inputs_mid_supply),
    .o_inputs_connected(o_inputs_connected),
    .o_mon_temp_sensor(o_mon_temp_sensor),
    .o_mon_avdd_quarter(o_mon_avdd_quarter),
    .o_mon_dvdd_quarter(o_mon_dvdd_quarter), .o_amp_enable(o_amp_enable),
    .o_amp_analog_gain(o_amp_analog_gain), .o_digital_shift(o_digital_shift),
    .o_ref_source_select(o_ref_source_select),
    .o_internal_ref_on(o_internal_ref_on)
);

//--- tb/tb_afcc_top.sv
// Self-checking bench for the front-end control block
`timescale 1ns/1ps
module tb_afcc_top;
    // One table row: write, then decoded outputs expected
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic [8:0] outs;
    } afcc_row_t;
    logic clk = 1'h0, rst = 1'h1, en = 1'h1, wr_en = 1'h0, rd_en = 1'h0;
    logic pd = 1'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic rvalid, mid, conn, temp, avdd, dvdd, amp_en, ref_on;
    logic [3:0] pos, neg;
    logic [2:0] gain;
    logic [1:0] shift, src;
    int mismatches = 0, checked = 0;
    wire [8:0] dec = {amp_en, gain, shift, src, ref_on};
    afcc_row_t rows [10] = '{
        '{8'h03, 8'h20, 9'h100}, '{8'h03, 8'h26, 9'h1a8},
        '{8'h03, 8'h27, 9'h1b0}, '{8'h03, 8'h24, 9'h180},
        '{8'h03, 8'h00, 9'h000}, '{8'h03, 8'h03, 9'h160},
        '{8'h05, 8'h08, 9'h161}, '{8'h05, 8'h0a, 9'h165},
        '{8'h05, 8'h05, 9'h163}, '{8'h05, 8'h00, 9'h160}};

    afcc_top afcc_top_inst (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_reg_wr(wr_en),
        .i_reg_rd(rd_en), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_power_down(pd),
        .o_pos_input_select(pos), .o_neg_input_select(neg),
        .o_inputs_mid_supply(mid), .o_inputs_connected(conn),
        .o_mon_temp_sensor(temp), .o_mon_avdd_quarter(avdd),
        .o_mon_dvdd_quarter(dvdd), .o_amp_enable(amp_en),
        .o_amp_analog_gain(gain), .o_digital_shift(shift),
        .o_ref_source_select(src), .o_internal_ref_on(ref_on));

    ////////////////////////////////////////////////////////////////////////
    // Free-running system clock
    always #5 clk = ~clk;

    task check(input string what, input logic [8:0] seen,
        input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Sample just after an edge so the edge's updates have landed
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'h0;
        #1;
    endtask
    task reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_en <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'h0;
        #1;
        check("rvalid", rvalid, 9'h1);
        check("rdata", rdata, exp);
    endtask
    task wrap_up;
        $display("Comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        tick(1);
        check("reset decode", dec, 9'h000);
        check("reset pair", {conn, pos, neg}, 9'h101);
        reg_read(8'h02, 8'h01);
        reg_read(8'h07, 8'h00);
        $display("reset test done");
        // Table walk over gain, amp and reference codes
        // only legal amp codes
        foreach (rows[k]) begin
            reg_write(rows[k].addr, rows[k].data);
            tick(1);
            check("decode", dec, rows[k].outs);
            reg_read(rows[k].addr, rows[k].data);
        end
        $display("table test done");
        // Common input on the negative side, break first
        reg_write(8'h02, 8'h3c);
        tick(1);
        check("break 1", {mid, conn}, 9'h2);
        tick(1);
        check("break 2", {mid, conn}, 9'h2);
        tick(1);
        check("connect", {conn, pos, neg}, 9'h13c);
        $display("mux test done");
        // Monitor choices, each entered through a break
        for (int m = 1; m < 5; m++) begin
            reg_write(8'h09, 8'(m));
            tick(5);
            check("monitor", {mid, temp, avdd, dvdd},
                9'h10 >> m);
        end
        reg_write(8'h09, 8'h00);
        tick(5);
        check("reconnect", conn, 9'h1);
        $display("monitor test done");
        // Reserved amp code must leave the amp field alone
        reg_write(8'h03, 8'h44);
        tick(1);
        check("reserved", dec, 9'h180);
        reg_read(8'h03, 8'h04);
        $display("reserved test done");
        // Power-down drops only the switchable reference mode
        @(posedge clk) pd <= 1'h1;
        reg_write(8'h05, 8'h04);
        tick(1);
        check("ref pdown", ref_on, 9'h0);
        reg_write(8'h05, 8'h08);
        tick(1);
        check("ref always", ref_on, 9'h1);
        @(posedge clk) pd <= 1'h0;
        $display("power test done");
        // Frozen enable, unmapped and read-only writes are dropped
        @(posedge clk) en <= 1'h0;
        reg_write(8'h02, 8'h55);
        @(posedge clk) en <= 1'h1;
        reg_read(8'h02, 8'h3c);
        reg_write(8'h07, 8'hff);
        reg_write(8'h0a, 8'hff);
        reg_read(8'h07, 8'h00);
        reg_read(8'h0a, 8'h06);
        $display("refusal test done");
        wrap_up();
    end

    // Watchdog well beyond the about 124 cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule // tb_afcc_top
